// ---- common/xosc_pkg.sv ----
// Package: register map, field layout, codes and timing for the crystal startup control
package xosc_pkg;
   // Register byte offsets
   localparam logic [7:0]  CTRL_OFF         = 8'h00;
   localparam logic [7:0]  STATUS_OFF       = 8'h04;
   localparam logic [7:0]  PAUSE_OFF        = 8'h08;
   localparam logic [7:0]  STARTUP_OFF      = 8'h0C;
   localparam logic [7:0]  MODE_OFF         = 8'h20;
   // Control register fields
   localparam int          CTRL_EN_LSB      = 12;
   localparam int          CTRL_EN_MSB      = 23;
   localparam int          CTRL_FR_LSB      = 0;
   localparam int          CTRL_FR_MSB      = 11;
   localparam logic [11:0] EN_CODE_DISABLE  = 12'hD1E;
   localparam logic [11:0] EN_CODE_ENABLE   = 12'hFAB;
   localparam logic [11:0] FR_CODE_1_15MHZ  = 12'hAA0;
   localparam logic [11:0] FR_RESET         = 12'h000;
   // Status register fields
   localparam int          ST_STABLE_BIT    = 31;
   localparam int          ST_BADWR_BIT     = 24;
   localparam int          ST_ENABLED_BIT   = 12;
   // Startup register fields
   localparam int          SU_X4_BIT        = 20;
   localparam int          SU_DLY_LSB       = 0;
   localparam int          SU_DLY_MSB       = 13;
   localparam logic [13:0] SU_DLY_RESET     = 14'h002F;
   // Pause register codes
   localparam logic [31:0] PAUSE_CODE_STOP  = 32'h0000_00A5;
   localparam logic [31:0] PAUSE_CODE_RUN   = 32'h0000_005A;
   // Mode register field
   localparam int          MODE_BYPASS_BIT  = 0;
   // Startup timing
   localparam int          UNIT_CYCLES      = 256;
   localparam int          PRE_W            = 8;
   localparam int          UNIT_W           = 16;
   localparam int          X4_SHIFT         = 2;
endpackage : xosc_pkg

// ---- hw/xosc_startup_ctrl.sv ----
// Crystal oscillator enable, startup timer and APB register slave
// Summary of operation
// - Oscillator is held disabled from reset; chip runs from ring oscillator.
// - Startup timer counts crystal cycles in units of 256.
// - Stable flag sets when the timer reaches the programmed count.
// - Default delay gives about one millisecond at twelve megahertz.
// - Oscillator output feeds the PLL reference and the clock generators.
// - Bypass mode disables the amplifier; external clock drives crystal input.
// - Twelve-bit enable code; disable code disables, any other value enables unless paused.
// - Invalid writes to enable, frequency range or pause set the bad-write flag.
// - Delay-times-four bit multiplies the startup wait by four.
module xosc_startup_ctrl (
   input  wire logic        pclk,            // APB clock, 20 MHz
   input  wire logic        presetn,         // Asynchronous reset, active low
   input  wire logic        psel,            // APB select
   input  wire logic        penable,         // APB access phase
   input  wire logic        pwrite,          // APB direction, high for write
   input  wire logic [7:0]  paddr,           // APB byte address
   input  wire logic [31:0] pwdata,          // APB write data
   output logic             pready,          // APB ready
   output logic      [31:0] prdata,          // APB read data
   output logic             pslverr,         // APB error on unmapped address
   input  wire logic        crystal_in_pin,  // Sampled level of the crystal input
   output logic             amp_enable,      // Enables the crystal amplifier driving the out pin
   output logic             osc_enabled,     // Oscillator enabled, not necessarily stable
   output logic             osc_stable,      // Oscillator output usable as a clock
   output logic             pll_ref_out,     // Reference for the PLLs, gated until stable
   output logic             clkgen_src_out   // Source offered to the clock generators
);

   typedef struct packed {
      // Software-visible settings
      logic [11:0]                      enable_code;
      logic [11:0]                      freq_range;
      logic                             paused;
      logic                             bypass;
      logic [13:0]                      delay;
      logic                             x4;
      logic                             bad_write;
      // Status and startup timer
      logic                             enabled;
      logic                             stable;
      logic                             xin_q;
      logic                             xin_prev;
      logic [xosc_pkg::PRE_W-1:0]       pre_cnt;
      logic [xosc_pkg::UNIT_W-1:0]      unit_cnt;
      // Registered bus answer
      logic                             pready;
      logic                             pslverr;
      logic [31:0]                      prdata;
      // Registered pin outputs
      logic                             amp_en;
      logic                             pll_ref;
      logic                             gen_src;
   } xosc_state_s;

   xosc_state_s st;
   xosc_state_s next_st;

   // Address decode shared by the read and write paths; unmapped offsets answer with an error
   function automatic logic xosc_mapped(input logic [7:0] addr);
      logic hit;
      hit = 1'b0;
      case (addr)
         xosc_pkg::CTRL_OFF,
         xosc_pkg::STATUS_OFF,
         xosc_pkg::PAUSE_OFF,
         xosc_pkg::STARTUP_OFF,
         xosc_pkg::MODE_OFF: begin
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      xosc_mapped = hit;
   endfunction : xosc_mapped

   // Read mux built from current register contents
   function automatic logic [31:0] xosc_read(input xosc_state_s s, input logic [7:0] addr);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (addr)
         xosc_pkg::CTRL_OFF: begin
            d[xosc_pkg::CTRL_EN_MSB:xosc_pkg::CTRL_EN_LSB] = s.enable_code;
            d[xosc_pkg::CTRL_FR_MSB:xosc_pkg::CTRL_FR_LSB] = s.freq_range;
         end
         xosc_pkg::STATUS_OFF: begin
            d[xosc_pkg::ST_STABLE_BIT]  = s.stable;
            d[xosc_pkg::ST_BADWR_BIT]   = s.bad_write;
            d[xosc_pkg::ST_ENABLED_BIT] = s.enabled;
         end
         xosc_pkg::PAUSE_OFF: begin
            d = s.paused ? xosc_pkg::PAUSE_CODE_STOP : xosc_pkg::PAUSE_CODE_RUN;
         end
         xosc_pkg::STARTUP_OFF: begin
            d[xosc_pkg::SU_X4_BIT] = s.x4;
            d[xosc_pkg::SU_DLY_MSB:xosc_pkg::SU_DLY_LSB] = s.delay;
         end
         xosc_pkg::MODE_OFF: begin
            d[xosc_pkg::MODE_BYPASS_BIT] = s.bypass;
         end
         default: begin
            d = 32'h0000_0000;
         end
      endcase
      xosc_read = d;
   endfunction : xosc_read

   // Enable code check; an unknown code still enables, but software is told via the flag
   function automatic logic xosc_en_code_bad(input logic [11:0] code);
      xosc_en_code_bad = (code != xosc_pkg::EN_CODE_ENABLE) &&
                         (code != xosc_pkg::EN_CODE_DISABLE);
   endfunction : xosc_en_code_bad

   // Pause code decode: bit 1 says the code is known, bit 0 the pause level it asks for
   function automatic logic [1:0] xosc_pause_decode(input logic [31:0] code);
      logic [1:0] r;
      if (code == xosc_pkg::PAUSE_CODE_STOP) begin
         r = 2'b11;
      end else if (code == xosc_pkg::PAUSE_CODE_RUN) begin
         r = 2'b10;
      end else begin
         r = 2'b00;
      end
      xosc_pause_decode = r;
   endfunction : xosc_pause_decode

   // Startup target in units of 256 crystal edges; times four widens it by two bits
   function automatic logic [xosc_pkg::UNIT_W-1:0] xosc_target(input logic [13:0] dly,
                                                                input logic        times4);
      logic [xosc_pkg::UNIT_W-1:0] t;
      if (times4) begin
         t = xosc_pkg::UNIT_W'({dly, 2'b00});
      end else begin
         t = xosc_pkg::UNIT_W'(dly);
      end
      xosc_target = t;
   endfunction : xosc_target

   logic                         setup_ph;
   logic                         wr_take;
   logic [11:0]                  wr_en_code;
   logic [11:0]                  wr_fr_code;
   logic                         bad_now;
   logic                         xin_rise;
   logic [xosc_pkg::UNIT_W-1:0]  target;
   logic                         en_now;
   logic [1:0]                   pause_dec;

   // Next-state logic; the whole block is one struct registered below.
   // Limitations worth knowing before reuse:
   // - the crystal input is treated as synchronous and only edge-counted, so a
   //   crystal faster than half of pclk loses edges and the wait stretches;
   // - a bypassed external clock is counted exactly like a crystal, so the same
   //   startup wait applies even though an external source needs none;
   // - writes to an unmapped offset are refused with pslverr and change nothing.
   always_comb begin
      next_st    = st;
      pause_dec  = 2'b00;
      setup_ph   = psel && !penable;
      // Writes land only on the completing access edge, which is when pready is high
      wr_take    = psel && penable && st.pready && pwrite && !st.pslverr;
      wr_en_code = pwdata[xosc_pkg::CTRL_EN_MSB:xosc_pkg::CTRL_EN_LSB];
      wr_fr_code = pwdata[xosc_pkg::CTRL_FR_MSB:xosc_pkg::CTRL_FR_LSB];
      bad_now    = 1'b0;

      // APB answer: ready and data prepared in setup, presented in the access cycle
      next_st.pready  = setup_ph;
      next_st.pslverr = setup_ph && !xosc_mapped(paddr);
      next_st.prdata  = (setup_ph && !pwrite) ? xosc_read(st, paddr) : 32'h0000_0000;

      // Register writes
      if (wr_take) begin
         case (paddr)
            xosc_pkg::CTRL_OFF: begin
               next_st.enable_code = wr_en_code;
               next_st.freq_range  = wr_fr_code;
               if (xosc_en_code_bad(wr_en_code)) begin
                  bad_now = 1'b1;
               end
               if (wr_fr_code != xosc_pkg::FR_CODE_1_15MHZ) begin
                  bad_now = 1'b1;
               end
            end
            xosc_pkg::STATUS_OFF: begin
               // Write one to clear the bad-write flag
               if (pwdata[xosc_pkg::ST_BADWR_BIT]) begin
                  next_st.bad_write = 1'b0;
               end
            end
            xosc_pkg::PAUSE_OFF: begin
               // Unknown codes leave the pause state alone and raise the flag
               pause_dec = xosc_pause_decode(pwdata);
               if (pause_dec[1]) begin
                  next_st.paused = pause_dec[0];
               end else begin
                  bad_now = 1'b1;
               end
            end
            xosc_pkg::STARTUP_OFF: begin
               next_st.delay = pwdata[xosc_pkg::SU_DLY_MSB:xosc_pkg::SU_DLY_LSB];
               next_st.x4    = pwdata[xosc_pkg::SU_X4_BIT];
            end
            xosc_pkg::MODE_OFF: begin
               next_st.bypass = pwdata[xosc_pkg::MODE_BYPASS_BIT];
            end
            default: begin
               next_st.bypass = st.bypass;
            end
         endcase
      end
      // Set beats a clear arriving in the same cycle
      if (bad_now) begin
         next_st.bad_write = 1'b1;
      end

      // Any code other than the disable code runs the oscillator unless paused
      en_now = (next_st.enable_code != xosc_pkg::EN_CODE_DISABLE) && !next_st.paused;
      next_st.enabled = en_now;

      // Edge detect on the crystal input; limited to crystals well below pclk/2
      next_st.xin_q    = crystal_in_pin;
      next_st.xin_prev = st.xin_q;
      xin_rise         = st.xin_q && !st.xin_prev;

      // Programmed wait in units of 256 crystal cycles, optionally times four
      target = xosc_target(st.delay, st.x4);

      if (!en_now || !st.enabled) begin
         // Disabled, or first cycle of a fresh enable: restart from zero
         next_st.pre_cnt  = '0;
         next_st.unit_cnt = '0;
         next_st.stable   = 1'b0;
      end else if (!st.stable) begin
         if (st.unit_cnt >= target) begin
            next_st.stable = 1'b1;
         end else if (xin_rise) begin
            next_st.pre_cnt = st.pre_cnt + xosc_pkg::PRE_W'(1);
            if (st.pre_cnt == xosc_pkg::PRE_W'(xosc_pkg::UNIT_CYCLES - 1)) begin
               next_st.unit_cnt = st.unit_cnt + xosc_pkg::UNIT_W'(1);
            end
         end
      end

      // Amplifier runs only when enabled and not bypassed
      next_st.amp_en  = en_now && !next_st.bypass;
      // Clock consumers only see the input once it is stable
      next_st.pll_ref = st.stable && st.xin_q;
      next_st.gen_src = st.stable && st.xin_q;
   end

   // State register; reset leaves the oscillator disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st.enable_code <= xosc_pkg::EN_CODE_DISABLE;
         st.freq_range  <= xosc_pkg::FR_RESET;
         st.paused      <= 1'b0;
         st.bypass      <= 1'b0;
         st.delay       <= xosc_pkg::SU_DLY_RESET;
         st.x4          <= 1'b0;
         st.bad_write   <= 1'b0;
         st.enabled     <= 1'b0;
         st.stable      <= 1'b0;
         st.xin_q       <= 1'b0;
         st.xin_prev    <= 1'b0;
         st.pre_cnt     <= '0;
         st.unit_cnt    <= '0;
         st.pready      <= 1'b0;
         st.pslverr     <= 1'b0;
         st.prdata      <= 32'h0000_0000;
         st.amp_en      <= 1'b0;
         st.pll_ref     <= 1'b0;
         st.gen_src     <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state flops
   assign pready         = st.pready;
   assign prdata         = st.prdata;
   assign pslverr        = st.pslverr;
   assign amp_enable     = st.amp_en;
   assign osc_enabled    = st.enabled;
   assign osc_stable     = st.stable;
   assign pll_ref_out    = st.pll_ref;
   assign clkgen_src_out = st.gen_src;

endmodule : xosc_startup_ctrl

// ---- verif/xosc_crystal_model.sv ----
// Crystal or external clock source facing the crystal input
module xosc_crystal_model #(
   parameter int HALF = 2  // Half period in pclk cycles, 5 MHz
) (
   input  wire logic pclk, // Bench clock
   input  wire logic run,  // Amplifier on or external drive
   output logic      pin   // Crystal input level
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial pin = 1'b0;
   // No swing without the amplifier or an external drive, so the pin rests low between runs
   always @(posedge pclk) begin
      if (!run || cnt == HALF - 1) begin
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
      pin <= run && (cnt == HALF - 1 ? !pin : pin);
   end
endmodule : xosc_crystal_model

// ---- verif/xosc_startup_ctrl_assertions.sv ----
// Checker for handshake, enable codes, startup timing and clock gating
module xosc_startup_ctrl_chk (
   input wire logic        pclk,           // Clock
   input wire logic        presetn,        // Reset
   input wire logic        psel,           // Select
   input wire logic        penable,        // Access
   input wire logic        pwrite,         // Write
   input wire logic [7:0]  paddr,          // Address
   input wire logic [31:0] pwdata,         // Write data
   input wire logic        pready,         // Ready
   input wire logic [31:0] prdata,         // Read data
   input wire logic        pslverr,        // Error
   input wire logic        crystal_in_pin, // Crystal
   input wire logic        amp_enable,     // Amplifier
   input wire logic        osc_enabled,    // Enabled
   input wire logic        osc_stable,     // Stable
   input wire logic        pll_ref_out,    // PLL ref
   input wire logic        clkgen_src_out  // Gen source
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        wr, paused, xin_q, x4;
   logic [13:0] dly;
   int          cnt, tgt;
   assign wr  = psel && penable && pwrite && pready;
   assign tgt = (x4 ? int'(dly) * 4 : int'(dly)) * 256;
   // Shadow of the delay setting; own edge count runs ahead of the synchronised one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly    <= xosc_pkg::SU_DLY_RESET;
         x4     <= 1'b0;
         paused <= 1'b0;
         xin_q  <= 1'b0;
         cnt    <= 0;
      end else begin
         xin_q <= crystal_in_pin;
         if (wr && paddr == xosc_pkg::STARTUP_OFF) begin
            dly <= pwdata[13:0];
            x4  <= pwdata[xosc_pkg::SU_X4_BIT];
         end
         if (wr && paddr == xosc_pkg::PAUSE_OFF) begin
            if (pwdata == xosc_pkg::PAUSE_CODE_STOP) paused <= 1'b1;
            if (pwdata == xosc_pkg::PAUSE_CODE_RUN) paused <= 1'b0;
         end
         if (!osc_enabled || paused) cnt <= 0;
         else if (crystal_in_pin && !xin_q) cnt <= cnt + 1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_after_setup_a: assert property (psel && !penable |=> pready && penable)
      else $error("Access cycle without ready");
   unmapped_err_a: assert property (pready && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C,
      8'h20}) |-> pslverr && prdata == 32'h0) else $error("Unmapped access not refused");
   enable_by_write_a:
      assert property ($rose(osc_enabled) |-> $past(wr) || $past(wr, 2))
      else $error("Enable rose without a write");
   enable_code_a:
      assert property (wr && paddr == 8'h00 && pwdata[23:12] != xosc_pkg::EN_CODE_DISABLE
      && !paused |-> ##[1:2] osc_enabled) else $error("Enable code ignored");
   disable_code_a:
      assert property (wr && paddr == 8'h00 && pwdata[23:12] == xosc_pkg::EN_CODE_DISABLE
      |-> ##[1:2] !osc_enabled && !osc_stable) else $error("Disable code ignored");
   stable_not_early_a:
      assert property ($rose(osc_stable) |-> cnt >= tgt) else $error("Stable too early");
   stable_on_time_a:
      assert property (osc_enabled && !paused && cnt > tgt + 2 |-> ##[0:16] osc_stable)
      else $error("Stable too late");
   stable_needs_en_a:
      assert property (osc_stable |-> osc_enabled) else $error("Stable while disabled");
   ref_gated_a:
      assert property (pll_ref_out || clkgen_src_out |-> osc_stable || $past(osc_stable))
      else $error("Clock out before stable");
   amp_needs_en_a:
      assert property (amp_enable |-> osc_enabled) else $error("Amplifier on while disabled");
   cover property ($rose(osc_stable));
   cover property (pready && pslverr);
   cover property ($fell(osc_enabled));
endmodule : xosc_startup_ctrl_chk

bind xosc_startup_ctrl xosc_startup_ctrl_chk i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .crystal_in_pin(crystal_in_pin), .amp_enable(amp_enable), .osc_enabled(osc_enabled),
   .osc_stable(osc_stable), .pll_ref_out(pll_ref_out), .clkgen_src_out(clkgen_src_out));

// ---- verif/xosc_startup_ctrl_tb_top.sv ----
// Self-checking bench: reset state, startup timing, codes and bad writes
module xosc_startup_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        ext_on = 1'b0, err, xin_q = 1'b0, x4, tog;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd, seed = 32'hF6E8;
   logic [13:0] dly;
   wire  logic  pready, pslverr, crystal_in_pin, amp_enable, osc_enabled, osc_stable;
   wire  logic  pll_ref_out, clkgen_src_out;
   wire  logic [31:0] prdata;
   int          mismatches = 0, compares = 0, edges = 0, e0, xp, n;
   // Write table: address, data, bad flag expected, amplifier expected
   logic [7:0]  wa [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
   logic [31:0] wd [6] = '{32'h0012_3AA0, 32'h00FA_B001, 32'h0000_00A5, 32'h0000_005A,
                           32'h00D1_EAA0, 32'h0000_0077};
   logic [5:0]  wb = 6'b100011, wm = 6'b001011;
   xosc_startup_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .crystal_in_pin(crystal_in_pin), .amp_enable(amp_enable),
      .osc_enabled(osc_enabled), .osc_stable(osc_stable), .pll_ref_out(pll_ref_out),
      .clkgen_src_out(clkgen_src_out));
   xosc_crystal_model i_xtal (.pclk(pclk), .run(amp_enable || ext_on), .pin(crystal_in_pin));
   initial begin
      forever #25 pclk = ~pclk;
   end
   // Own count of crystal edges, to bound the startup wait from both sides
   always @(posedge pclk) begin
      xin_q <= crystal_in_pin;
      if (crystal_in_pin && !xin_q) edges <= edges + 1;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Units of 256 for a crystal in kHz and a wait in us, rounded up
   function automatic logic [31:0] exp_delay(int khz, int us);
      return 32'((khz * us / 1000 + 255) / 256);
   endfunction : exp_delay
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One transfer; waits on ready with a bound, then an idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 40);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 40) mismatches++;
      @(posedge pclk);
   endtask : apb
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (90000) @(posedge pclk);
      mismatches++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, xosc_pkg::CTRL_OFF, 32'h0);
      chk("ctrl", rd, {8'h00, xosc_pkg::EN_CODE_DISABLE, xosc_pkg::FR_RESET});
      apb(1'b0, xosc_pkg::STATUS_OFF, 32'h0);
      chk("status", rd, 32'h0);
      apb(1'b0, xosc_pkg::STARTUP_OFF, 32'h0);
      chk("startup", rd, exp_delay(12000, 1000));
      apb(1'b0, 8'h10, 32'h0);
      chk("slverr", 32'(err), 32'h1);
      // Random short delays, x4 on odd runs, external clock on run one
      for (int i = 0; i < 4; i++) begin
         dly = 14'(rnd() & 32'h3);
         x4 = i[0];
         ext_on <= (i == 1);
         apb(1'b1, xosc_pkg::MODE_OFF, 32'(i == 1));
         apb(1'b1, xosc_pkg::STARTUP_OFF, {11'h0, x4, 6'h0, dly});
         e0 = edges;
         apb(1'b1, xosc_pkg::CTRL_OFF, {8'h00, xosc_pkg::EN_CODE_ENABLE, 12'hAA0});
         n = 0;
         while (osc_stable !== 1'b1 && n < 20000) begin
            @(posedge pclk);
            n++;
         end
         xp = int'(dly) * (x4 ? 4 : 1) * xosc_pkg::UNIT_CYCLES;
         chk("edges", 32'(edges - e0 >= xp && edges - e0 <= xp + 4), 32'h1);
         chk("amp", 32'(amp_enable), 32'(i != 1));
         tog = 1'b0;
         repeat (16) begin
            @(posedge pclk);
            tog |= pll_ref_out && clkgen_src_out;
         end
         chk("ref_out", 32'(tog), 32'h1);
         apb(1'b0, xosc_pkg::STATUS_OFF, 32'h0);
         chk("stable", rd, 32'h8000_1000);
         apb(1'b1, xosc_pkg::CTRL_OFF, {8'h00, xosc_pkg::EN_CODE_DISABLE, 12'hAA0});
         chk("stable_off", 32'(osc_stable), 32'h0);
      end
      for (int j = 0; j < 6; j++) begin
         apb(1'b1, wa[j], wd[j]);
         apb(1'b0, xosc_pkg::STATUS_OFF, 32'h0);
         chk("bad_write", 32'(rd[xosc_pkg::ST_BADWR_BIT]), 32'(wb[j]));
         chk("amp_state", 32'(amp_enable), 32'(wm[j]));
         apb(1'b1, xosc_pkg::STATUS_OFF, 32'h0100_0000);
      end
      report_and_stop();
   end
endmodule : xosc_startup_ctrl_tb_top
